// [sss_cfg.svh]
// How it works
// - Low output voltage below threshold flips signal
// - Current above threshold flips signal
// - Power above threshold flips signal
// - Operating hours past limit flips signal
// - Pre-derating temperature warning flips signal
// - Overvoltage clamp active flips signal
// - Mains failure flagged ten ms before shutoff
// - Phase loss or imbalance flags two-phase
// - Remaining life below threshold flips signal
// - Relay closes only with correct phase order
// - Selected options combine into one output
// - External party writes selection and thresholds
// - Output-good LED steady or blinking
// - First power LED above half load
// - Second power LED above three quarters
// - Boost LED above nominal power
// - Link LED steady with link supply
// - Link LED blinks while communicating
// - Default relay opens on low voltage
// - Sleep darkens LEDs, opens relay
`ifndef SSS_CFG_SVH
`define SSS_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SSS_OFS_CTRL   12'h000
`define SSS_OFS_VTH    12'h004
`define SSS_OFS_ITH    12'h008
`define SSS_OFS_PTH    12'h00c
`define SSS_OFS_HLIM   12'h010
`define SSS_OFS_LTH    12'h014
`define SSS_OFS_STAT   12'h018
`define SSS_OFS_HCNT   12'h01c

// ----------------------------------------
// Control fields
// ----------------------------------------
`define SSS_CTRL_AND   16
`define SSS_CTRL_SLEEP 24

// ----------------------------------------
// Option bit positions
// ----------------------------------------
`define SSS_OPT_VOLT  0
`define SSS_OPT_CURR  1
`define SSS_OPT_POWR  2
`define SSS_OPT_HOUR  3
`define SSS_OPT_TEMP  4
`define SSS_OPT_CLMP  5
`define SSS_OPT_MAIN  6
`define SSS_OPT_PHAS  7
`define SSS_OPT_LIFE  8
`define SSS_OPT_SEQ   9
`define SSS_NOPT      10

// ----------------------------------------
// Reset values and ranges
// ----------------------------------------
`define SSS_SEL_RST   10'h001
`define SSS_VTH_RST   8'h5a
`define SSS_VTH_MIN   8'h19
`define SSS_VTH_MAX   8'h87
`define SSS_ITH_RST   8'h64
`define SSS_ITH_MIN   8'h05
`define SSS_ITH_MAX   8'h96
`define SSS_HLIM_RST  20'h15630
`define SSS_LTH_RST   16'h0000
`define SSS_IMB_MAX   8'h0a
`define SSS_LED_GOOD  8'h5a
`define SSS_LED_P50   8'h32
`define SSS_LED_P75   8'h4b
`define SSS_LED_P100  8'h64

// ----------------------------------------
// Timing
// ----------------------------------------
`define SSS_CLK_HZ        100000000
`define SSS_MAINS_WARN_MS 10
`define SSS_BLINK_HZ      1

`endif

// [sss_pkg.sv]
package sss_pkg;

  // Mains warning sequence states
  typedef enum logic [1:0] {
    SSS_MAINS_OK,
    SSS_MAINS_WARN,
    SSS_MAINS_OFF
  } sss_mains_t;

  // Option vector
  typedef logic [9:0] sss_opt_t;

endpackage : sss_pkg

// [sss_signaling.sv]
`timescale 1ns/1ns
`default_nettype none
`include "sss_cfg.svh"

module sss_signaling
  import sss_pkg::*;
#(
  parameter int unsigned MAINS_WARN_CYC =
    `SSS_MAINS_WARN_MS * (`SSS_CLK_HZ / 1000),
  parameter int unsigned BLINK_HALF_CYC =
    `SSS_CLK_HZ / (2 * `SSS_BLINK_HZ)
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Measurements, percent of setpoint or nominal
  input  wire logic [7:0]  volt_pct,
  input  wire logic [7:0]  curr_pct,
  input  wire logic [7:0]  powr_pct,
  input  wire logic        hour_tick,
  input  wire logic        derate_imminent,
  input  wire logic        overvoltage_clamp_flag,
  input  wire logic        mains_present_flag,
  input  wire logic        output_off_request,
  input  wire logic [2:0]  phase_present,
  input  wire logic [7:0]  phase_imbalance_pct,
  input  wire logic        rotation_correct,
  input  wire logic [15:0] life_remaining,
  input  wire logic        iol_supply_present,
  input  wire logic        iol_comm_active,
  // Outputs
  output logic             output_enable,
  output logic             mains_fail_warning,
  output logic             two_phase_operation,
  output logic             three_phase_healthy_flag,
  output logic             relay_closed,
  output logic             output_good_indicator,
  output logic             led_p50,
  output logic             led_p75,
  output logic             led_boost,
  output logic             led_iolink
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------

  // Saturate a written threshold into its range
  function automatic logic [7:0] sss_clamp(
    input logic [7:0] v,
    input logic [7:0] lo,
    input logic [7:0] hi
  );
    logic [7:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction : sss_clamp

  // Register offset match
  function automatic logic sss_hit(
    input logic [11:0] a,
    input logic [11:0] ofs
  );
    return a == ofs;
  endfunction : sss_hit

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  sss_opt_t    sel_reg;
  logic        and_mode_reg;
  logic        sleep_reg;
  logic [7:0]  vth_reg;
  logic [7:0]  ith_reg;
  logic [7:0]  pth_reg;
  logic [19:0] hlim_reg;
  logic [15:0] lth_reg;
  logic [19:0] hours_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;

  logic        wr_en;
  logic        rd_setup;
  logic        mapped;

  // Zero wait states; a frozen block stalls the bus
  assign pready  = ce;
  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg;

  assign wr_en    = ce && psel && penable && pwrite;
  assign rd_setup = ce && psel && !penable;

  // Address decode
  assign mapped = sss_hit(paddr, `SSS_OFS_CTRL) ||
                  sss_hit(paddr, `SSS_OFS_VTH)  ||
                  sss_hit(paddr, `SSS_OFS_ITH)  ||
                  sss_hit(paddr, `SSS_OFS_PTH)  ||
                  sss_hit(paddr, `SSS_OFS_HLIM) ||
                  sss_hit(paddr, `SSS_OFS_LTH)  ||
                  sss_hit(paddr, `SSS_OFS_STAT) ||
                  sss_hit(paddr, `SSS_OFS_HCNT);

  // Writable configuration, defaults kept until rewritten
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_reg      <= `SSS_SEL_RST;
      and_mode_reg <= 1'b0;
      sleep_reg    <= 1'b0;
      vth_reg      <= `SSS_VTH_RST;
      ith_reg      <= `SSS_ITH_RST;
      pth_reg      <= `SSS_ITH_RST;
      hlim_reg     <= `SSS_HLIM_RST;
      lth_reg      <= `SSS_LTH_RST;
    end else if (wr_en) begin
      if (sss_hit(paddr, `SSS_OFS_CTRL)) begin
        sel_reg      <= pwdata[`SSS_NOPT-1:0];
        and_mode_reg <= pwdata[`SSS_CTRL_AND];
        sleep_reg    <= pwdata[`SSS_CTRL_SLEEP];
      end
      if (sss_hit(paddr, `SSS_OFS_VTH)) begin
        vth_reg <= sss_clamp(pwdata[7:0], `SSS_VTH_MIN, `SSS_VTH_MAX);
      end
      if (sss_hit(paddr, `SSS_OFS_ITH)) begin
        ith_reg <= sss_clamp(pwdata[7:0], `SSS_ITH_MIN, `SSS_ITH_MAX);
      end
      if (sss_hit(paddr, `SSS_OFS_PTH)) begin
        pth_reg <= sss_clamp(pwdata[7:0], `SSS_ITH_MIN, `SSS_ITH_MAX);
      end
      if (sss_hit(paddr, `SSS_OFS_HLIM)) begin
        hlim_reg <= pwdata[19:0];
      end
      if (sss_hit(paddr, `SSS_OFS_LTH)) begin
        lth_reg <= pwdata[15:0];
      end
    end
  end

  // ----------------------------------------
  // Operating hours
  // ----------------------------------------

  // Accumulates hour ticks, holds at full scale
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hours_reg <= 20'h00000;
    end else if (ce && hour_tick && (hours_reg != 20'hfffff)) begin
      hours_reg <= hours_reg + 20'h00001;
    end
  end

  // ----------------------------------------
  // Mains failure warning
  // ----------------------------------------
  sss_mains_t  mains_st_reg;
  logic [31:0] warn_cnt_reg;
  logic        warn_done;

  assign warn_done = warn_cnt_reg >= (MAINS_WARN_CYC - 1);

  // Flag at once, allow shutoff only after the lead time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mains_st_reg <= SSS_MAINS_OK;
      warn_cnt_reg <= 32'h00000000;
    end else if (ce) begin
      case (mains_st_reg)
        SSS_MAINS_OK: begin
          warn_cnt_reg <= 32'h00000000;
          if (!mains_present_flag) begin
            mains_st_reg <= SSS_MAINS_WARN;
          end
        end
        SSS_MAINS_WARN: begin
          if (mains_present_flag) begin
            mains_st_reg <= SSS_MAINS_OK;
          end else if (warn_done) begin
            mains_st_reg <= SSS_MAINS_OFF;
          end else begin
            warn_cnt_reg <= warn_cnt_reg + 32'h00000001;
          end
        end
        SSS_MAINS_OFF: begin
          if (mains_present_flag) begin
            mains_st_reg <= SSS_MAINS_OK;
          end
        end
        default: begin
          mains_st_reg <= SSS_MAINS_OK;
        end
      endcase
    end
  end

  // Output may only drop once the warning has stood long enough
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_enable      <= 1'b1;
      mains_fail_warning <= 1'b0;
    end else if (ce) begin
      mains_fail_warning <= !mains_present_flag ||
                            (mains_st_reg != SSS_MAINS_OK);
      output_enable <= !(output_off_request &&
                         (mains_st_reg == SSS_MAINS_OFF));
    end
  end

  // ----------------------------------------
  // Option evaluation and combining
  // ----------------------------------------
  sss_opt_t opt_fault;
  sss_opt_t opt_reg;
  logic     any_sel;
  logic     combined;
  logic     phase_loss;
  logic     healthy;

  assign phase_loss = phase_present != 3'b111;
  assign healthy    = !phase_loss && rotation_correct;

  // A set bit means the option reports a problem
  always_comb begin
    opt_fault                = '0;
    opt_fault[`SSS_OPT_VOLT] = volt_pct < vth_reg;
    opt_fault[`SSS_OPT_CURR] = curr_pct > ith_reg;
    opt_fault[`SSS_OPT_POWR] = powr_pct > pth_reg;
    opt_fault[`SSS_OPT_HOUR] = hours_reg > hlim_reg;
    opt_fault[`SSS_OPT_TEMP] = derate_imminent;
    opt_fault[`SSS_OPT_CLMP] = overvoltage_clamp_flag;
    opt_fault[`SSS_OPT_MAIN] = mains_st_reg != SSS_MAINS_OK ||
                               !mains_present_flag;
    opt_fault[`SSS_OPT_PHAS] = phase_loss ||
                               phase_imbalance_pct > `SSS_IMB_MAX;
    opt_fault[`SSS_OPT_LIFE] = life_remaining < lth_reg;
    opt_fault[`SSS_OPT_SEQ]  = !healthy;
  end

  assign any_sel = |sel_reg;

  // OR mode: any selected fault; AND mode: all selected faults
  assign combined = !any_sel ? 1'b0 :
                    and_mode_reg ? ((opt_reg & sel_reg) == sel_reg) :
                    |(opt_reg & sel_reg);

  // Registered option state and phase flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt_reg                  <= '0;
      two_phase_operation      <= 1'b0;
      three_phase_healthy_flag <= 1'b0;
    end else if (ce) begin
      opt_reg                  <= opt_fault;
      two_phase_operation      <= opt_fault[`SSS_OPT_PHAS];
      three_phase_healthy_flag <= healthy;
    end
  end

  // Normally open contact closes while all is well
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relay_closed <= 1'b0;
    end else if (ce) begin
      relay_closed <= !sleep_reg && !combined;
    end
  end

  // ----------------------------------------
  // Blink divider
  // ----------------------------------------
  logic [31:0] blink_cnt_reg;
  logic        blink_reg;

  // Free-running half-period counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt_reg <= 32'h00000000;
      blink_reg     <= 1'b0;
    end else if (ce) begin
      if (blink_cnt_reg >= (BLINK_HALF_CYC - 1)) begin
        blink_cnt_reg <= 32'h00000000;
        blink_reg     <= !blink_reg;
      end else begin
        blink_cnt_reg <= blink_cnt_reg + 32'h00000001;
      end
    end
  end

  // ----------------------------------------
  // Front LEDs
  // ----------------------------------------

  // Fixed indicators, all dark in sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_good_indicator <= 1'b0;
      led_p50               <= 1'b0;
      led_p75               <= 1'b0;
      led_boost             <= 1'b0;
      led_iolink            <= 1'b0;
    end else if (ce) begin
      if (sleep_reg) begin
        output_good_indicator <= 1'b0;
        led_p50               <= 1'b0;
        led_p75               <= 1'b0;
        led_boost             <= 1'b0;
        led_iolink            <= 1'b0;
      end else begin
        output_good_indicator <= (volt_pct >= `SSS_LED_GOOD) ? 1'b1 :
                                 blink_reg;
        led_p50   <= powr_pct > `SSS_LED_P50;
        led_p75   <= powr_pct > `SSS_LED_P75;
        led_boost <= powr_pct > `SSS_LED_P100;
        if (!iol_supply_present) begin
          led_iolink <= 1'b0;
        end else if (iol_comm_active) begin
          led_iolink <= blink_reg;
        end else begin
          led_iolink <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [31:0] rd_mux;

  // Read value selection by address
  always_comb begin
    rd_mux = 32'h00000000;
    if (sss_hit(paddr, `SSS_OFS_CTRL)) begin
      rd_mux[`SSS_NOPT-1:0]   = sel_reg;
      rd_mux[`SSS_CTRL_AND]   = and_mode_reg;
      rd_mux[`SSS_CTRL_SLEEP] = sleep_reg;
    end
    if (sss_hit(paddr, `SSS_OFS_VTH)) begin
      rd_mux[7:0] = vth_reg;
    end
    if (sss_hit(paddr, `SSS_OFS_ITH)) begin
      rd_mux[7:0] = ith_reg;
    end
    if (sss_hit(paddr, `SSS_OFS_PTH)) begin
      rd_mux[7:0] = pth_reg;
    end
    if (sss_hit(paddr, `SSS_OFS_HLIM)) begin
      rd_mux[19:0] = hlim_reg;
    end
    if (sss_hit(paddr, `SSS_OFS_LTH)) begin
      rd_mux[15:0] = lth_reg;
    end
    if (sss_hit(paddr, `SSS_OFS_STAT)) begin
      rd_mux[`SSS_NOPT-1:0] = opt_reg;
      rd_mux[`SSS_CTRL_AND] = relay_closed;
    end
    if (sss_hit(paddr, `SSS_OFS_HCNT)) begin
      rd_mux[19:0] = hours_reg;
    end
  end

  // Captured in setup, presented during access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else if (rd_setup) begin
      prdata_reg  <= pwrite ? 32'h00000000 : rd_mux;
      pslverr_reg <= !mapped;
    end
  end

endmodule : sss_signaling

`default_nettype wire

// [sss_signaling_sva.sv]
`timescale 1ns/1ns
`default_nettype none
// --------------------------------
// Status signaling checker
// --------------------------------
module sss_signaling_sva #(
  parameter int unsigned MAINS_WARN_CYC = 16
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  powr_pct,
  input wire logic        mains_present_flag,
  input wire logic        output_off_request,
  input wire logic [2:0]  phase_present,
  input wire logic [7:0]  phase_imbalance_pct,
  input wire logic        iol_supply_present,
  input wire logic        mains_fail_warning,
  input wire logic        output_enable,
  input wire logic        two_phase_operation,
  input wire logic        led_p50,
  input wire logic        led_p75,
  input wire logic        led_boost,
  input wire logic        led_iolink
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [31:0] wcnt_reg;
  // Consecutive cycles of mains warning seen so far
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wcnt_reg <= '0;
    else if (mains_fail_warning) wcnt_reg <= wcnt_reg + 32'h1;
    else wcnt_reg <= '0;
  end
  sequence s_mains_lost; $fell(mains_present_flag); endsequence
  sequence s_out_drop; $fell(output_enable); endsequence
  chk_pready_ce: assert property (pready == ce)
    else $error("pready differs from ce");
  chk_bad_addr: assert property (ce && psel && !penable && paddr > 12'h01c |=> pslverr)
    else $error("no error for unmapped address");
  chk_p50_cause: assert property (led_p50 && $past(ce) |-> $past(powr_pct) > 8'h32)
    else $error("half load lamp without load");
  chk_p75_stack: assert property (led_p75 && $past(ce) |->
    led_p50 && $past(powr_pct) > 8'h4b)
    else $error("three quarter lamp wrong");
  chk_boost_stack: assert property (led_boost && $past(ce) |->
    led_p75 && $past(powr_pct) > 8'h64)
    else $error("boost lamp wrong");
  chk_warn_early: assert property (s_mains_lost |=> mains_fail_warning)
    else $error("mains warning late");
  // Warning has stood its full span when the output drops
  chk_warn_span: assert property (s_out_drop |->
    wcnt_reg >= MAINS_WARN_CYC && $past(output_off_request))
    else $error("output dropped too early");
  chk_phase_flag: assert property ($past(presetn) |->
    two_phase_operation == $past(phase_present != 3'h7 || phase_imbalance_pct > 8'h0a))
    else $error("two phase flag wrong");
  chk_iol_dark: assert property ($past(presetn) && !$past(iol_supply_present) |-> !led_iolink)
    else $error("link lamp lit without supply");
  cover property (s_out_drop);
endmodule : sss_signaling_sva
bind sss_signaling sss_signaling_sva #(.MAINS_WARN_CYC(MAINS_WARN_CYC)) u_sva (.pclk, .presetn,
  .ce, .psel, .penable, .paddr, .pready, .pslverr, .powr_pct, .mains_present_flag,
  .output_off_request, .phase_present, .phase_imbalance_pct, .iol_supply_present,
  .mains_fail_warning, .output_enable, .two_phase_operation, .led_p50, .led_p75,
  .led_boost, .led_iolink);
`default_nettype wire

// [sss_signaling_test.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end
module sss_signaling_test;
  localparam int WARN = 16;
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, hour_tick = 1'b0, derate_imminent = 1'b0, mains_cut = 1'b0;
  logic overvoltage_clamp_flag = 1'b0, rotation_correct = 1'b1, err;
  logic iol_supply_present = 1'b0, iol_comm_active = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0]  volt_pct = 8'h5f, curr_pct = 8'h32, powr_pct = 8'h28;
  logic [7:0]  phase_imbalance_pct = 8'h00;
  logic [2:0]  phase_present = 3'h7;
  logic [15:0] life_remaining = 16'h03e8;
  logic pready, pslverr, output_enable, mains_fail_warning, two_phase_operation;
  logic three_phase_healthy_flag, relay_closed, output_good_indicator, led_p50;
  logic led_p75, led_boost, led_iolink, mains_present_flag, output_off_request;
  int   num_errors = 0, n_checks = 0, t;
  // --------------------------------
  // Block, stage model and clock
  // --------------------------------
  sss_signaling #(.MAINS_WARN_CYC(WARN), .BLINK_HALF_CYC(4)) uut (.pclk, .presetn, .ce,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .volt_pct,
    .curr_pct, .powr_pct, .hour_tick, .derate_imminent, .overvoltage_clamp_flag,
    .mains_present_flag, .output_off_request, .phase_present, .phase_imbalance_pct,
    .rotation_correct, .life_remaining, .iol_supply_present, .iol_comm_active,
    .output_enable, .mains_fail_warning, .two_phase_operation, .three_phase_healthy_flag,
    .relay_closed, .output_good_indicator, .led_p50, .led_p75, .led_boost, .led_iolink);
  sss_stage_model u_stage (.pclk, .presetn, .mains_cut, .mains_present_flag,
    .output_off_request);
  always #5 pclk = ~pclk;
  // --------------------------------
  // Bus and helper tasks
  // --------------------------------
  task cyc(input int n); repeat (n) @(posedge pclk); endtask : cyc
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the slave; only the watchdog ends a hang
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task wr(input logic [11:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask : wr
  // Lamp changes over twelve cycles
  task watch(input bit w, output int n);
    logic p;
    n = 0;
    repeat (12) begin
      p = w ? led_iolink : output_good_indicator;
      @(posedge pclk);
      if ((w ? led_iolink : output_good_indicator) !== p) n++;
    end
  endtask : watch
  // Raise or clear the fault behind one option
  task flt(input int i, input bit v);
    case (i)
      0: volt_pct <= v ? 8'h59 : 8'h5a;
      1: curr_pct <= v ? 8'h65 : 8'h64;
      2: powr_pct <= v ? 8'h65 : 8'h64;
      3: if (v) repeat (3) begin hour_tick <= 1'b1; cyc(1); hour_tick <= 1'b0; cyc(1); end
         else wr(12'h010, 32'hfffff);
      4: derate_imminent <= v;
      5: overvoltage_clamp_flag <= v;
      6: mains_cut <= v;
      7: phase_present <= v ? 3'h5 : 3'h7;
      8: life_remaining <= v ? 16'h0063 : 16'h0064;
      default: rotation_correct <= !v;
    endcase
  endtask : flt
  // --------------------------------
  // Scenarios
  // --------------------------------
  task t_regs;
    apb(0, 12'h000, 0); `CHK("ctrl", 32'h1, rd)
    apb(0, 12'h004, 0); `CHK("vth", 32'h5a, rd)
    apb(0, 12'h00c, 0); `CHK("pth", 32'h64, rd)
    apb(0, 12'h010, 0); `CHK("hlim", 32'h15630, rd)
    wr(12'h01c, 32'h5); apb(0, 12'h01c, 0); `CHK("hcnt", 32'h0, rd)
    apb(0, 12'h040, 0); `CHK("slverr", 1'b1, err)
    wr(12'h004, 32'h3); apb(0, 12'h004, 0); `CHK("vth_lo", 32'h19, rd)
    wr(12'h008, 32'hff); apb(0, 12'h008, 0); `CHK("ith_hi", 32'h96, rd)
    wr(12'h004, 32'h5a); wr(12'h008, 32'h64);
    flt(0, 1); cyc(3); `CHK("dflt_relay", 1'b0, relay_closed)
    flt(0, 0);
  endtask : t_regs
  task t_opts;
    wr(12'h010, 32'h2); wr(12'h014, 32'h64);
    for (int i = 0; i < 10; i++) begin
      wr(12'h000, 32'h1 << i);
      flt(i, 1); cyc(3); `CHK("opt_on", 1'b0, relay_closed)
      flt(i, 0); cyc(4); `CHK("opt_off", 1'b1, relay_closed)
    end
    phase_imbalance_pct <= 8'h0a; cyc(2); `CHK("imb10", 1'b0, two_phase_operation)
    phase_imbalance_pct <= 8'h0b; cyc(2); `CHK("imb11", 1'b1, two_phase_operation)
    `CHK("healthy", 1'b1, three_phase_healthy_flag)
    rotation_correct <= 1'b0; cyc(2); `CHK("rot_bad", 1'b0, three_phase_healthy_flag)
    rotation_correct <= 1'b1;
    phase_imbalance_pct <= 8'h00;
    wr(12'h000, 32'h10003); volt_pct <= 8'h59; cyc(3);
    `CHK("and_one", 1'b1, relay_closed)
    curr_pct <= 8'h65; cyc(3); `CHK("and_both", 1'b0, relay_closed)
    volt_pct <= 8'h5a; curr_pct <= 8'h32; wr(12'h000, 32'h1);
  endtask : t_opts
  task t_leds;
    logic [7:0] pv[6];
    int nl[6];
    pv = '{8'h32, 8'h33, 8'h4b, 8'h4c, 8'h64, 8'h65};
    nl = '{0, 1, 1, 2, 2, 3};
    for (int i = 0; i < 6; i++) begin
      powr_pct <= pv[i]; cyc(2);
      `CHK("p50", nl[i] > 0, led_p50)
      `CHK("p75", nl[i] > 1, led_p75)
      `CHK("boost", nl[i] > 2, led_boost)
    end
    volt_pct <= 8'h59; cyc(2); watch(0, t); `CHK("good_blink", 1'b1, t >= 2)
    volt_pct <= 8'h5a; cyc(2); watch(0, t); `CHK("good_steady", 0, t)
    `CHK("good_on", 1'b1, output_good_indicator)
    `CHK("iol_dark", 1'b0, led_iolink)
    iol_supply_present <= 1'b1; cyc(2); watch(1, t); `CHK("iol_steady", 0, t)
    `CHK("iol_on", 1'b1, led_iolink)
    iol_comm_active <= 1'b1; cyc(2); watch(1, t); `CHK("iol_blink", 1'b1, t >= 2)
    // Clock enable low freezes the lamps
    ce <= 1'b0; powr_pct <= 8'h28; cyc(3); `CHK("ce_hold", 1'b1, led_p50)
    ce <= 1'b1; cyc(2); `CHK("ce_run", 1'b0, led_p50)
  endtask : t_leds
  task t_mains;
    mains_cut <= 1'b1; cyc(2); `CHK("warn", 1'b1, mains_fail_warning)
    t = 0;
    while (output_enable === 1'b1 && t < 60) begin cyc(1); t++; end
    `CHK("off_late", 1'b1, t >= WARN)
    `CHK("off_done", 1'b0, output_enable)
    mains_cut <= 1'b0; cyc(3); `CHK("back_on", 1'b1, output_enable)
  endtask : t_mains
  task t_sleep;
    powr_pct <= 8'h65; wr(12'h000, 32'h1000001); cyc(3);
    `CHK("sleep", 6'h0, {output_good_indicator, led_p50, led_p75, led_boost, led_iolink,
      relay_closed})
    wr(12'h000, 32'h1);
  endtask : t_sleep
  // Mid-run reset restores defaults
  task t_reset;
    wr(12'h004, 32'h30); presetn <= 1'b0; cyc(2);
    `CHK("rst_oe", 1'b1, output_enable)
    `CHK("rst_p50", 1'b0, led_p50)
    presetn <= 1'b1;
    apb(0, 12'h004, 0); `CHK("rst_vth", 32'h5a, rd)
  endtask : t_reset
  task stop_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  // Main sequence after five reset cycles
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs; t_opts; t_leds; t_mains; t_sleep; t_reset;
    stop_test;
  end
  // Watchdog
  initial begin
    #300000;
    num_errors++;
    stop_test;
  end
endmodule : sss_signaling_test
`default_nettype wire

// [sss_stage_model.sv]
`timescale 1ns/1ns
`default_nettype none
// --------------------------------
// Power stage model on mains loss
// --------------------------------
module sss_stage_model #(
  parameter int unsigned OFF_DLY = 4
) (
  input wire logic  pclk,
  input wire logic  presetn,
  input wire logic  mains_cut,
  output logic      mains_present_flag,
  output logic      output_off_request
);
  logic [7:0] cnt_reg;
  // Stage asks to stop soon after mains goes, well before the warning ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_reg <= '0;
    else if (!mains_cut) cnt_reg <= '0;
    else if (cnt_reg != 8'hff) cnt_reg <= cnt_reg + 8'h1;
  end
  assign mains_present_flag = !mains_cut;
  assign output_off_request = cnt_reg >= OFF_DLY;
endmodule : sss_stage_model
`default_nettype wire
